/* logic/gpioc_defines.vh */
/*
 Constants for the pin control slice: register offsets, field positions,
 reset values and timing counts. Assumes inclusion by bare name.
*/
`ifndef GPIOC_DEFINES_VH
`define GPIOC_DEFINES_VH
`define GPIOC_ADDR_W            4
`define GPIOC_OFF_DIR           4'ha
`define GPIOC_OFF_LEVEL         4'hb
`define GPIOC_OFF_IRQ_EN        4'hc
`define GPIOC_OFF_CTRL          4'he
`define GPIOC_OFF_EFC           4'hf
`define GPIOC_RST_DIR           8'h00
`define GPIOC_RST_LEVEL         8'hff
`define GPIOC_RST_IRQ_EN        8'h00
`define GPIOC_RST_CTRL          8'h00
`define GPIOC_RST_EFC           8'h00
`define GPIOC_CTRL_LATCH        0
`define GPIOC_CTRL_MODEM_A      1
`define GPIOC_CTRL_MODEM_B      2
`define GPIOC_CTRL_SWRST        3
`define GPIOC_CTRL_MASK         8'h0f
`define GPIOC_EFC_IR_MODE       7
`define GPIOC_SWRST_CYCLES      4'h4
`endif

/* logic/gpioc_swrst.v */
/*
 Software reset sequencer: a write pulse starts a fixed-length reset pulse.
 Assumes start is a one-cycle pulse in the clk domain.
*/
module gpioc_swrst (
	input  wire       clk,      // System clock
	input  wire       sys_rst,  // Async reset, active high
	input  wire       start,    // Request pulse
	output reg        busy      // Reset in progress
);
`include "gpioc_defines.vh"
	reg [3:0] count;
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= 4'h0;
			busy  <= 1'b0;
		end else if (start && !busy) begin
			count <= `GPIOC_SWRST_CYCLES;
			busy  <= 1'b1;
		end else if (busy) begin
			count <= count - 4'h1;
			if (count == 4'h1)
				busy <= 1'b0;
		end
	end
endmodule // gpioc_swrst

/* logic/gpioc_pin_irq.v */
/*
 Per-pin change detector with optional latching. Assumes level is already
 synchronous to clk.
*/
module gpioc_pin_irq (
	input  wire       clk,       // System clock
	input  wire       rst,       // Async reset incl. software reset
	input  wire       level,     // Sampled pin level
	input  wire       enable,    // Interrupt allowed for this pin
	input  wire       latch_en,  // Latching mode
	input  wire       read_ack,  // Level register read pulse
	output reg        shown,     // Level reported to software
	output reg        pending    // Pending interrupt
);
	reg ref_level;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_level <= 1'b1;
			shown     <= 1'b1;
			pending   <= 1'b0;
		end else begin
			if (read_ack) begin
				ref_level <= shown;
				shown     <= level;
			end else if (!(latch_en && pending)) begin
				shown <= level;
			end
			if (enable && level != ref_level && !read_ack)
				pending <= 1'b1;
			else if (!latch_en && level == ref_level)
				pending <= 1'b0;
			else if (read_ack)
				pending <= 1'b0;
			else if (!enable)
				pending <= pending & latch_en;
		end
	end
endmodule // gpioc_pin_irq

/* logic/gpioc_top.v */
/*
 Pin control slice: direction, level, interrupt enable, control and extra
 feature registers, per-pin interrupts, modem nibble select, software reset.
 Assumes a simple synchronous register port from the host bus decoder.
*/
// Operation
// - Enable bits gate per-pin interrupts
// - Modem nibbles ignore interrupt enables
// - Control bit 3 write resets device
// - Software reset bit clears itself
// - Bit 2 selects lower nibble modem
// - Bit 1 selects upper nibble modem
// - Bit 0 selects input latching
// - Unlatched revert withdraws pending interrupt
// - Latched interrupt persists, level held
// - Extra feature bit 7 selects infrared
// - Direction bit one makes output
// - Level read pins, write outputs
// - Software reset resets all channels
module gpioc_top (
	input  wire       clk,          // System clock 40 MHz
	input  wire       sys_rst,      // Async reset, active high
	input  wire [3:0] reg_addr,     // Register offset
	input  wire       reg_wr,       // Write strobe
	input  wire       reg_rd,       // Read strobe
	input  wire [7:0] reg_wdata,    // Write data
	output reg  [7:0] reg_rdata,    // Read data
	input  wire [7:0] pin_in,       // Pin levels
	output reg  [7:0] pin_out,      // Pin drive levels
	output wire [7:0] pin_oe_n,     // Pin drive enable, low drives
	input  wire       term_ready_a_n, // Channel A terminal ready from UART
	input  wire       term_ready_b_n, // Channel B terminal ready from UART
	output wire       ring_in_a_n,  // Channel A ring in
	output wire       carrier_in_a_n, // Channel A carrier detect
	output wire       set_ready_a_n,  // Channel A set ready
	output wire       ring_in_b_n,  // Channel B ring in
	output wire       carrier_in_b_n, // Channel B carrier detect
	output wire       set_ready_b_n,  // Channel B set ready
	output wire       gpio_irq,     // Any pin interrupt pending
	output wire       ir_quarter,   // Infrared quarter-bit pulse mode
	output wire       dev_rst       // Device-wide reset
);
`include "gpioc_defines.vh"
	reg  [7:0] pin_direction_reg;
	reg  [7:0] pin_level_reg;
	reg  [7:0] pin_interrupt_enable;
	reg  [2:0] pin_control;
	reg  [7:0] extra_feature_control;
	wire       swrst_busy;
	wire       core_rst;
	wire [7:0] shown;
	wire [7:0] pending;
	wire [7:0] modem_mask;
	wire       wr_ctrl;
	wire       level_rd;

	////////////////////////////////////////////////////////////////
	// one reset for all but the sequencer and the read data register
	assign core_rst = sys_rst | swrst_busy;
	assign dev_rst  = core_rst;
	assign wr_ctrl  = reg_wr && reg_addr == `GPIOC_OFF_CTRL;
	assign level_rd = reg_rd && reg_addr == `GPIOC_OFF_LEVEL;

	gpioc_swrst u_swrst (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (wr_ctrl && reg_wdata[`GPIOC_CTRL_SWRST]),
		.busy    (swrst_busy)
	);

	////////////////////////////////////////////////////////////////
	// Registers; core_rst loads their reset values, level 8'hff and the rest 0; control keeps bits 2:0 only, so the reset bit is never held
	always @(posedge clk or posedge core_rst) begin
		if (core_rst) begin
			pin_direction_reg     <= `GPIOC_RST_DIR;
			pin_level_reg         <= `GPIOC_RST_LEVEL;
			pin_interrupt_enable  <= `GPIOC_RST_IRQ_EN;
			pin_control           <= 3'h0;
			extra_feature_control <= `GPIOC_RST_EFC;
		end else if (reg_wr) begin
			case (reg_addr)
				`GPIOC_OFF_DIR:    pin_direction_reg    <= reg_wdata;
				`GPIOC_OFF_LEVEL:  pin_level_reg        <= reg_wdata;
				`GPIOC_OFF_IRQ_EN: pin_interrupt_enable <= reg_wdata;
				`GPIOC_OFF_CTRL:   pin_control <= reg_wdata[2:0];
				`GPIOC_OFF_EFC:    extra_feature_control <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// modem nibble mask: upper nibble from bit 1, lower nibble from bit 2
	assign modem_mask = {{4{pin_control[`GPIOC_CTRL_MODEM_A]}},
		{4{pin_control[`GPIOC_CTRL_MODEM_B]}}};

	// direction drives pin
	// Modem nibbles drive only their terminal ready pins, bits 5 and 1
	assign pin_oe_n = ~((pin_direction_reg & ~modem_mask) | (modem_mask & 8'h22));

	always @(posedge clk or posedge core_rst) begin
		if (core_rst)
			pin_out <= `GPIOC_RST_LEVEL;
		else begin
			pin_out[7:4] <= pin_control[`GPIOC_CTRL_MODEM_A] ?
				{2'b11, term_ready_a_n, 1'b1} : pin_level_reg[7:4];
			pin_out[3:0] <= pin_control[`GPIOC_CTRL_MODEM_B] ?
				{2'b11, term_ready_b_n, 1'b1} : pin_level_reg[3:0];
		end
	end

	// Modem pins: ring, carrier, terminal ready, set ready, high to low bit
	assign ring_in_a_n    = pin_control[`GPIOC_CTRL_MODEM_A] ? pin_in[7] : 1'b1;
	assign carrier_in_a_n = pin_control[`GPIOC_CTRL_MODEM_A] ? pin_in[6] : 1'b1;
	assign set_ready_a_n  = pin_control[`GPIOC_CTRL_MODEM_A] ? pin_in[4] : 1'b1;
	assign ring_in_b_n    = pin_control[`GPIOC_CTRL_MODEM_B] ? pin_in[3] : 1'b1;
	assign carrier_in_b_n = pin_control[`GPIOC_CTRL_MODEM_B] ? pin_in[2] : 1'b1;
	assign set_ready_b_n  = pin_control[`GPIOC_CTRL_MODEM_B] ? pin_in[0] : 1'b1;

	////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_pin
			gpioc_pin_irq u_pin (
				.clk      (clk),
				.rst      (core_rst),
				.level    (pin_in[i]),
				.enable   (pin_interrupt_enable[i] & ~modem_mask[i]
					& ~pin_direction_reg[i]),
				.latch_en (pin_control[`GPIOC_CTRL_LATCH]),
				.read_ack (level_rd),
				.shown    (shown[i]),
				.pending  (pending[i])
			);
		end
	endgenerate

	assign gpio_irq = |(pending & pin_interrupt_enable & ~modem_mask);

	assign ir_quarter = extra_feature_control[`GPIOC_EFC_IR_MODE];

	////////////////////////////////////////////////////////////////
	// Read data registered: available the cycle after the strobe
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
				`GPIOC_OFF_DIR:    reg_rdata <= pin_direction_reg;
				`GPIOC_OFF_LEVEL:  reg_rdata <= (shown & ~pin_direction_reg)
					| (pin_level_reg & pin_direction_reg);
				`GPIOC_OFF_IRQ_EN: reg_rdata <= pin_interrupt_enable;
				`GPIOC_OFF_CTRL:   reg_rdata <= {5'h00, pin_control} & `GPIOC_CTRL_MASK;
				`GPIOC_OFF_EFC:    reg_rdata <= extra_feature_control;
				default:           reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule // gpioc_top

/* tb/gpioc_chk_sva.sv */
/* Assertions on the pin control slice ports.
 Assumes a bind from the bench top. */
module gpioc_chk (
	input logic       clk,            // Clock
	input logic       sys_rst,        // Reset
	input logic [3:0] reg_addr,       // Offset
	input logic       reg_wr,         // Write
	input logic       reg_rd,         // Read
	input logic [7:0] reg_wdata,      // Wdata
	input logic [7:0] reg_rdata,      // Rdata
	input logic [7:0] pin_in,         // Pins
	input logic [7:0] pin_oe_n,       // Drive
	input logic       ring_in_a_n,    // Ring A
	input logic       carrier_in_a_n, // CD A
	input logic       ring_in_b_n,    // Ring B
	input logic       gpio_irq,       // Irq
	input logic       ir_quarter,     // IR
	input logic       dev_rst         // Reset out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Writes inside a device reset are dropped; reads still load reg_rdata
	wire rd_ok = reg_rd && !dev_rst;
	wire wr_ok = reg_wr && !dev_rst;
	property p_sw; wr_ok && reg_addr == 4'he && reg_wdata[3] |=> dev_rst[*4] ##1 !dev_rst; endproperty
	a_sw: assert property (p_sw) else $error("bad reset pulse");
	property p_ir; rd_ok && reg_addr == 4'hf |=> reg_rdata[7] == ir_quarter; endproperty
	a_ir: assert property (p_ir) else $error("ir mode mismatch");
	property p_cr; rd_ok && reg_addr == 4'he |=> reg_rdata[7:3] == 5'h00; endproperty
	a_cr: assert property (p_cr) else $error("control high bits set");
	property p_um; rd_ok && reg_addr == 4'hd |=> reg_rdata == 8'h00; endproperty
	a_um: assert property (p_um) else $error("unmapped read");
	property p_hd; !reg_rd |=> $stable(reg_rdata); endproperty
	a_hd: assert property (p_hd) else $error("read data moved");
	property p_ma; !carrier_in_a_n |-> !pin_in[6] && ring_in_a_n == pin_in[7]; endproperty
	a_ma: assert property (p_ma) else $error("modem a pins");
	property p_mb; !ring_in_b_n |-> !pin_in[3]; endproperty
	a_mb: assert property (p_mb) else $error("modem b pins");
	property p_rs; dev_rst && $past(dev_rst) |-> !gpio_irq && !ir_quarter && pin_oe_n == 8'hff; endproperty
	a_rs: assert property (p_rs) else $error("state kept in reset");
endmodule // gpioc_chk

/* tb/gpioc_pins.sv */
/* Board side of the eight pins.
 Assumes the bench sets the board levels. */
module gpioc_pins (
	input  logic [7:0] lvl,      // Board levels
	input  logic [7:0] pin_out,  // Device levels
	input  logic [7:0] pin_oe_n, // Low drives
	output logic [7:0] pin_in    // Wire levels
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pin_in = (pin_out & ~pin_oe_n) | (lvl & pin_oe_n);
endmodule // gpioc_pins

/* tb/testbench.sv */
/* Self-checking bench for the pin control slice.
 Assumes design, checker and pin model compiled first. */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, sys_rst, reg_wr, reg_rd, pend;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, lvl, q[$];
	logic [1:0] tr;
	wire  [7:0] reg_rdata, pin_out, pin_oe_n, pin_in;
	wire        ra, rb, irq, irm;
	wire  [3:0] mo;
	int         bad_count, n_checks, i;
	gpioc_top u_dut (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.pin_in, .pin_out, .pin_oe_n, .term_ready_a_n(tr[1]), .term_ready_b_n(tr[0]),
		.ring_in_a_n(ra), .carrier_in_a_n(mo[3]), .set_ready_a_n(mo[2]), .ring_in_b_n(rb),
		.carrier_in_b_n(mo[1]), .set_ready_b_n(mo[0]), .gpio_irq(irq), .ir_quarter(irm),
		.dev_rst());
	gpioc_pins u_pins (.lvl, .pin_out, .pin_oe_n, .pin_in);
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(negedge clk) reg_wr = 0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
		q.push_back(e);
		@(negedge clk) reg_rd = 0;
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Read data lands one edge after the strobe, so compare half a cycle later
	always @(posedge clk) pend <= reg_rd;
	always @(negedge clk) if (pend) chk(reg_rdata, q.pop_front());
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#20us;
		bad_count++;
		wrap_up;
	end
	initial begin
		{sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, tr} = {1'b1, 14'h0000, 2'b11};
		{bad_count, n_checks, lvl} = {32'd0, 32'd0, 8'hff};
		i = $urandom(32'h8b42);
		repeat (3) @(negedge clk);
		sys_rst = 0;
		rd(4'hc, 8'h00);
		rd(4'he, 8'h00);
		rd(4'hb, 8'hff);
		wr(4'hd, 8'h5a);
		rd(4'hd, 8'h00);
		wr(4'hf, 8'h80);
		rd(4'hf, 8'h80);
		chk(irm, 1'b1);
		for (i = 0; i < 8; i++) begin
			lvl = $urandom & 8'hb7;
			tr = 2'($urandom);
			wr(4'he, 8'(i));
			rd(4'he, 8'(i));
			chk({ra, mo[3:2], pin_in[5]}, i[1] ? {lvl[7:6], lvl[4], tr[1]} : {3'h7, lvl[5]});
			chk({rb, mo[1:0], pin_in[1]}, i[2] ? {lvl[3:2], lvl[0], tr[0]} : {3'h7, lvl[1]});
		end
		wr(4'he, 8'h00);
		lvl = $urandom;
		wr(4'ha, 8'h0f);
		wr(4'hb, 8'h5a);
		rd(4'hb, {lvl[7:4], 4'ha});
		lvl = 8'hff;
		rd(4'hb, 8'hfa);
		wr(4'hc, 8'h80);
		lvl[7] = 0;
		repeat (2) @(negedge clk);
		chk(irq, 1'b1);
		lvl[7] = 1;
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		wr(4'he, 8'h01);
		lvl[7] = 0;
		repeat (2) @(negedge clk);
		lvl[7] = 1;
		repeat (2) @(negedge clk);
		chk(irq, 1'b1);
		rd(4'hb, 8'h7a);
		wr(4'he, 8'h02);
		chk(irq, 1'b0);
		wr(4'he, 8'h08);
		repeat (5) @(negedge clk);
		rd(4'he, 8'h00);
		rd(4'hc, 8'h00);
		rd(4'hf, 8'h00);
		rd(4'ha, 8'h00);
		// Let the last read's compare run before the verdict
		@(negedge clk);
		wrap_up;
	end
endmodule // testbench
bind gpioc_top gpioc_chk u_chk (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
	.reg_rdata, .pin_in, .pin_oe_n, .ring_in_a_n, .carrier_in_a_n, .ring_in_b_n, .gpio_irq,
	.ir_quarter, .dev_rst);
